// ---- rtl/cmb_pkg.sv ----
// package: status codes, timing counts and bus widths for the multiplexed bus
package cmb_pkg;
  localparam int ADDR_W = 16;
  localparam int SEG_W  = 7;
  // cycle status codes, bit 3 first
  localparam logic [3:0] ST_INTERNAL   = 4'h0;
  localparam logic [3:0] ST_REFRESH    = 4'h1;
  localparam logic [3:0] ST_IO_NORMAL  = 4'h2;
  localparam logic [3:0] ST_IO_SPECIAL = 4'h3;
  localparam logic [3:0] ST_SEGMENT_TRAP_N_ACK   = 4'h4;
  localparam logic [3:0] ST_NMI_ACK    = 4'h5;
  localparam logic [3:0] ST_PLAIN_ACK  = 4'h6;
  localparam logic [3:0] ST_VEC_ACK    = 4'h7;
  localparam logic [3:0] ST_MEM_OPND   = 4'h8;
  localparam logic [3:0] ST_MEM_STACK  = 4'h9;
  localparam logic [3:0] ST_FETCH_NEXT = 4'hc;
  localparam logic [3:0] ST_FETCH_FIRST = 4'hd;
  // fixed wait states inserted after an acknowledge status
  localparam logic [2:0] ACK_WAITS = 3'h5;
  // flag and control word bit positions
  localparam int FCW_SYS_BIT  = 14;
  localparam int FCW_VIE_BIT  = 12;
  localparam int FCW_PLAIN_IRQ_ENABLE_BIT = 11;
  localparam logic [15:0] FCW_RESET = 16'h4000;
  // one request from the user side of the device end
  typedef struct packed {
    logic [3:0]        code;
    logic              rdNotWr;
    logic              byteXfer;
    logic [SEG_W-1:0]  seg;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] wdata;
  } cmb_req_t;
endpackage

// ---- rtl/cmb_bus_if.sv ----
// interface: multiplexed address/data bus, strobes, status and bus handover
`timescale 1ns/1ps
interface cmb_bus_if;
  import cmb_pkg::*;
  logic [15:0] adOutCpu, adOutDma, adIn;
  logic        adOeCpu, adOeDma;
  logic        addrStrobeNCpu, dataStrobeNCpu, readNotWriteCpu, byteNotWordCpu;
  logic        normalNotSysCpu, memRequestNCpu, ctlOeCpu;
  logic [3:0]  statusCpu;
  logic [6:0]  segCpu;
  logic        addrStrobeNDma, dataStrobeNDma, readNotWriteDma, byteNotWordDma;
  logic        normalNotSysDma, memRequestNDma, ctlOeDma;
  logic [3:0]  statusDma;
  logic [6:0]  segDma;
  logic        waitN, busRequestInN, busGrantOutN, nmiN, vectoredIrqN, plainIrqN;
  logic        segmentTrapN;
  // resolved levels seen by the testbench and the checker, not in either modport
  logic addrStrobeN, dataStrobeN, readNotWrite, byteNotWord, memRequestN;
  logic [3:0] status;
  assign addrStrobeN  = ctlOeCpu ? addrStrobeNCpu : ctlOeDma ? addrStrobeNDma : 1'b1;
  assign dataStrobeN  = ctlOeCpu ? dataStrobeNCpu : ctlOeDma ? dataStrobeNDma : 1'b1;
  assign readNotWrite = ctlOeCpu ? readNotWriteCpu : readNotWriteDma;
  assign byteNotWord  = ctlOeCpu ? byteNotWordCpu : byteNotWordDma;
  assign memRequestN  = ctlOeCpu ? memRequestNCpu : ctlOeDma ? memRequestNDma : 1'b1;
  assign status       = ctlOeCpu ? statusCpu : statusDma;
  modport cpu (
    output adOutCpu, adOeCpu, addrStrobeNCpu, dataStrobeNCpu, readNotWriteCpu,
    output byteNotWordCpu, normalNotSysCpu, memRequestNCpu, ctlOeCpu, statusCpu,
    output segCpu, busGrantOutN,
    input  adIn, waitN, busRequestInN, nmiN, vectoredIrqN, plainIrqN, segmentTrapN
  );
  modport dma (
    output adOutDma, adOeDma, addrStrobeNDma, dataStrobeNDma, readNotWriteDma,
    output byteNotWordDma, normalNotSysDma, memRequestNDma, ctlOeDma, statusDma,
    output segDma, busRequestInN,
    input  adIn, waitN, busGrantOutN
  );
endinterface

// ---- rtl/cmb_cpu_end.sv ----
// device end: bus cycle sequencer, bus handover and interrupt acceptance
// Functional notes
// - all transfers on one 16-bit muxed bus
// - address strobe low while address driven, except in internal cycles
// - read data taken at data strobe rise
// - write data held past data strobe rise
// - direction set at strobe fall, held
// - size set at strobe fall, held
// - word memory addresses always even
// - even byte address selects upper byte
// - io byte half chosen by low bit
// - transaction status codes as listed
// - acknowledge codes; four codes reserved
// - wait low inserts repeating wait states
// - privilege output from mode bit
// - memory request low for memory cycles
// - bus request synchronised, outputs float, grant
// - grant held low while request low
// - release request then grant returns high
// - nmi falling edge, highest interrupt priority after segment trap
// - vectored level irq gated by enable
// - plain level irq lowest, own enable
// - segment trap beats all interrupts
// - five waits before identifier strobe
`timescale 1ns/1ps
module cmb_cpu_end #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  cmb_bus_if.cpu                bus,
  input  wire cmb_pkg::cmb_req_t reqData,
  input  wire logic             reqValid,
  output logic                  reqReady,
  input  wire logic [15:0]      flagControlWord,
  output logic [15:0]           rspData,
  output logic                  rspValid,
  input  wire logic             rspReady,
  output logic [3:0]            irqTaken,
  output logic                  irqTakenValid
);
  import cmb_pkg::*;
  // elaboration check: the buffer pointers serve two entries only
  if (BUF_DEPTH != 2) begin : g_depthCheck
    $error("buffer depth must be 2");
  end

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_ADDR = 7'h02, S_DATA = 7'h04, S_WAIT = 7'h08,
    S_ACKW = 7'h10, S_DONE = 7'h20, S_HELD = 7'h40
  } cmb_state_t;

  //////////////////////////////////////////////////////////////////////
  // synchronisers and edge capture
  logic busReqS1_ff, busReqS2_ff, nmiPrev_ff, nmiPend_ff, nxt_nmiPend;
  always_ff @(posedge mclk) begin
    busReqS1_ff <= reset ? 1'b1 : bus.busRequestInN;
    busReqS2_ff <= reset ? 1'b1 : busReqS1_ff;
    nmiPrev_ff  <= reset ? 1'b1 : bus.nmiN;
    nmiPend_ff  <= reset ? 1'b0 : nxt_nmiPend;
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer state
  cmb_state_t  state_ff, nxt_state;
  cmb_req_t    cur_ff, nxt_cur;
  logic [2:0]  ackCnt_ff, nxt_ackCnt;
  logic [15:0] rdat_ff, nxt_rdat;
  logic        grantN_ff, nxt_grantN;
  logic        isAck_ff, nxt_isAck;
  logic [3:0]  ackCode;
  logic        ackWant, ackTake;

  // interrupt priority pick
  always_comb begin
    ackWant = 1'b1;
    ackCode = ST_SEGMENT_TRAP_N_ACK;
    if (!bus.segmentTrapN) ackCode = ST_SEGMENT_TRAP_N_ACK;
    else if (nmiPend_ff) ackCode = ST_NMI_ACK;
    else if (!bus.vectoredIrqN && flagControlWord[FCW_VIE_BIT]) ackCode = ST_VEC_ACK;
    else if (!bus.plainIrqN && flagControlWord[FCW_PLAIN_IRQ_ENABLE_BIT]) ackCode = ST_PLAIN_ACK;
    else ackWant = 1'b0;
  end
  assign ackTake = (state_ff == S_IDLE) && ackWant && busReqS2_ff;

  // two-entry response buffer
  logic [15:0] bufMem_ff [2];
  logic [1:0]  bufCnt_ff, nxt_bufCnt;
  logic        bufWr_ff, nxt_bufWr, bufRd_ff, nxt_bufRd;
  logic        pushRsp, popRsp;
  assign pushRsp  = (state_ff == S_DONE) && cur_ff.rdNotWr && !isAck_ff;
  assign popRsp   = rspValid && rspReady;
  assign rspValid = bufCnt_ff != 2'h0;
  assign rspData  = bufMem_ff[bufRd_ff];
  // a new read is refused while the buffer has no free slot
  assign reqReady = (state_ff == S_IDLE) && busReqS2_ff && !ackWant &&
                    bufCnt_ff != 2'h2;

  always_comb begin
    nxt_state   = state_ff;
    nxt_cur     = cur_ff;
    nxt_ackCnt  = ackCnt_ff;
    nxt_rdat    = rdat_ff;
    nxt_grantN  = grantN_ff;
    nxt_isAck   = isAck_ff;
    nxt_bufCnt  = bufCnt_ff + {1'b0, pushRsp} - {1'b0, popRsp};
    nxt_bufWr   = bufWr_ff ^ pushRsp;
    nxt_bufRd   = bufRd_ff ^ popRsp;
    // edge sets pending, set wins over clear
    nxt_nmiPend = (nmiPend_ff && !(ackTake && ackCode == ST_NMI_ACK)) ||
                  (nmiPrev_ff && !bus.nmiN);
    unique case (state_ff)
      S_IDLE: begin
        if (!busReqS2_ff) begin
          nxt_state  = S_HELD;
        end else if (ackWant) begin
          nxt_cur.code = ackCode;
          nxt_cur.rdNotWr = 1'b1;
          nxt_cur.byteXfer = 1'b0;
          nxt_isAck  = 1'b1;
          nxt_ackCnt = ACK_WAITS;
          nxt_state  = S_ADDR;
        end else if (reqValid && reqReady) begin
          nxt_cur = reqData;
          if (reqData.code[3] && reqData.code[1]) nxt_cur.code = ST_INTERNAL;
          if (reqData.code[3] && !reqData.byteXfer) nxt_cur.addr[0] = 1'b0;
          nxt_isAck  = 1'b0;
          nxt_ackCnt = 3'h0;
          nxt_state  = S_ADDR;
        end
      end
      S_ADDR: nxt_state = (ackCnt_ff != 3'h0) ? S_ACKW : S_DATA;
      S_ACKW: begin
        nxt_ackCnt = ackCnt_ff - 3'h1;
        if (ackCnt_ff == 3'h1) nxt_state = S_DATA;
      end
      S_DATA, S_WAIT: begin
        nxt_state = bus.waitN ? S_DONE : S_WAIT;
        if (bus.waitN) nxt_rdat = bus.adIn;
      end
      S_DONE: nxt_state = S_IDLE;
      S_HELD: begin
        // grant held; released after request rises
        nxt_grantN = busReqS2_ff;
        if (busReqS2_ff && !grantN_ff) nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff  <= S_IDLE;
      cur_ff    <= '0;
      ackCnt_ff <= 3'h0;
      rdat_ff   <= 16'h0;
      grantN_ff <= 1'b1;
      isAck_ff  <= 1'b0;
      bufCnt_ff <= 2'h0;
      bufWr_ff  <= 1'b0;
      bufRd_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cur_ff    <= nxt_cur;
      ackCnt_ff <= nxt_ackCnt;
      rdat_ff   <= nxt_rdat;
      grantN_ff <= nxt_grantN;
      isAck_ff  <= nxt_isAck;
      bufCnt_ff <= nxt_bufCnt;
      bufWr_ff  <= nxt_bufWr;
      bufRd_ff  <= nxt_bufRd;
    end
  end

  // response buffer storage
  always_ff @(posedge mclk) begin
    if (pushRsp) bufMem_ff[bufWr_ff] <= rdat_ff;
  end

  //////////////////////////////////////////////////////////////////////
  // pin drive
  logic inCycle, dataPhase, isMem, isInternal;
  assign inCycle    = state_ff inside {S_ADDR, S_ACKW, S_DATA, S_WAIT, S_DONE};
  assign dataPhase  = state_ff inside {S_DATA, S_WAIT};
  assign isMem      = cur_ff.code[3];
  assign isInternal = cur_ff.code == ST_INTERNAL;
  assign irqTaken      = cur_ff.code;
  assign irqTakenValid = (state_ff == S_DONE) && isAck_ff;

  always_comb begin
    bus.ctlOeCpu        = (state_ff != S_HELD);
    bus.addrStrobeNCpu  = !(state_ff == S_ADDR && !isInternal);
    bus.dataStrobeNCpu  = !(dataPhase && !isInternal);
    bus.readNotWriteCpu = inCycle ? cur_ff.rdNotWr : 1'b1;
    bus.byteNotWordCpu  = inCycle ? cur_ff.byteXfer : 1'b0;
    bus.memRequestNCpu  = !(inCycle && isMem);
    bus.statusCpu       = inCycle ? cur_ff.code : ST_INTERNAL;
    bus.normalNotSysCpu = !flagControlWord[FCW_SYS_BIT];
    bus.segCpu          = cur_ff.seg;
    bus.busGrantOutN    = grantN_ff;
    bus.adOeCpu  = (state_ff == S_ADDR) ||
                   (inCycle && !cur_ff.rdNotWr && !isInternal);
    bus.adOutCpu = (state_ff == S_ADDR) ? cur_ff.addr : cur_ff.wdata;
    // byte lane chosen by address low bit
    if (state_ff != S_ADDR && cur_ff.byteXfer)
      bus.adOutCpu = cur_ff.addr[0] ? {8'h00, cur_ff.wdata[7:0]}
                                    : {cur_ff.wdata[7:0], 8'h00};
  end
endmodule

// ---- rtl/cmb_dma_end.sv ----
// far end: bus requester that borrows the bus for one transfer at a time
`timescale 1ns/1ps
module cmb_dma_end (
  input  wire logic        mclk,
  input  wire logic        reset,
  cmb_bus_if.dma           bus,
  input  wire logic        xferValid,
  output logic             xferReady,
  input  wire logic        xferRead,
  input  wire logic [3:0]  xferCode,
  input  wire logic [15:0] xferAddr,
  input  wire logic [15:0] xferWdata,
  output logic [15:0]      xferRdata,
  output logic             xferDone
);
  import cmb_pkg::*;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01, D_REQ = 6'h02, D_ADDR = 6'h04, D_DATA = 6'h08,
    D_END = 6'h10, D_REL = 6'h20
  } cmb_dstate_t;

  //////////////////////////////////////////////////////////////////////
  // requester sequencer
  cmb_dstate_t state_ff, nxt_state;
  logic        rd_ff, nxt_rd;
  logic [3:0]  code_ff, nxt_code;
  logic [15:0] addr_ff, nxt_addr, wdat_ff, nxt_wdat, rdat_ff, nxt_rdat;
  logic        done_ff, nxt_done;

  assign xferReady = state_ff == D_IDLE;
  assign xferRdata = rdat_ff;
  assign xferDone  = done_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_rd    = rd_ff;
    nxt_code  = code_ff;
    nxt_addr  = addr_ff;
    nxt_wdat  = wdat_ff;
    nxt_rdat  = rdat_ff;
    nxt_done  = 1'b0;
    unique case (state_ff)
      D_IDLE: if (xferValid) begin
        nxt_rd = xferRead;
        nxt_code = xferCode;
        nxt_addr = xferAddr;
        nxt_wdat = xferWdata;
        nxt_state = D_REQ;
      end
      D_REQ:  if (!bus.busGrantOutN) nxt_state = D_ADDR;
      D_ADDR: nxt_state = D_DATA;
      D_DATA: if (bus.waitN) begin
        nxt_rdat  = bus.adIn;
        nxt_state = D_END;
      end
      D_END: begin
        nxt_done  = 1'b1;
        nxt_state = D_REL;
      end
      D_REL: if (bus.busGrantOutN) nxt_state = D_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= D_IDLE;
      rd_ff    <= 1'b1;
      code_ff  <= ST_INTERNAL;
      addr_ff  <= 16'h0;
      wdat_ff  <= 16'h0;
      rdat_ff  <= 16'h0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rd_ff    <= nxt_rd;
      code_ff  <= nxt_code;
      addr_ff  <= nxt_addr;
      wdat_ff  <= nxt_wdat;
      rdat_ff  <= nxt_rdat;
      done_ff  <= nxt_done;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // borrowed line drive, same shape as the device's cycle
  logic owning;
  assign owning = state_ff inside {D_ADDR, D_DATA, D_END};
  always_comb begin
    bus.busRequestInN   = !(state_ff inside {D_REQ, D_ADDR, D_DATA, D_END});
    bus.ctlOeDma        = owning;
    bus.addrStrobeNDma  = state_ff != D_ADDR;
    bus.dataStrobeNDma  = state_ff != D_DATA;
    bus.readNotWriteDma = rd_ff;
    bus.byteNotWordDma  = 1'b0;
    bus.normalNotSysDma = 1'b0;
    bus.memRequestNDma  = !code_ff[3];
    bus.statusDma       = code_ff;
    bus.segDma          = 7'h00;
    bus.adOeDma         = (state_ff == D_ADDR) || (owning && !rd_ff);
    bus.adOutDma        = (state_ff == D_ADDR) ? addr_ff : wdat_ff;
  end
endmodule

// ---- verification/cmb_bus_properties.sv ----
// checker: protocol properties of the device end on the shared bus
`timescale 1ns/1ps
module cmb_bus_properties (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        addrStrobeN,
  input wire logic        dataStrobeN,
  input wire logic        readNotWrite,
  input wire logic        byteNotWord,
  input wire logic        memRequestN,
  input wire logic [3:0]  status,
  input wire logic        ctlOeCpu,
  input wire logic        adOeCpu,
  input wire logic [15:0] adOutCpu,
  input wire logic        waitN,
  input wire logic        busRequestInN,
  input wire logic        busGrantOutN
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // address phase start, and its acknowledge flavour
  sequence addrPhase; ctlOeCpu && $fell(addrStrobeN); endsequence
  sequence ackPhase; addrPhase ##0 (status[3:2] == 2'b01); endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_no_reserved: assert property (ctlOeCpu |-> !(status[3] && status[1]))
    else $error("reserved status code driven");
  chk_quiet_internal: assert property (ctlOeCpu && status == 4'h0 |-> dataStrobeN && memRequestN)
    else $error("strobe during internal cycle");
  chk_mem_request: assert property (ctlOeCpu && !addrStrobeN && status != 4'h1 |-> memRequestN == !status[3])
    else $error("memory request does not match cycle type");
  chk_word_even: assert property (ctlOeCpu && !addrStrobeN && status[3] && !byteNotWord |-> !adOutCpu[0])
    else $error("odd word memory address");
  chk_addr_first: assert property (ctlOeCpu && $fell(dataStrobeN) && status[3:2] != 2'b01 |-> !$past(addrStrobeN))
    else $error("data strobe without address phase");
  chk_dir_hold: assert property (addrPhase |=> ($stable(readNotWrite) && $stable(byteNotWord))[*2])
    else $error("direction or size moved in cycle");
  chk_ack_waits: assert property (ackPhase |=> dataStrobeN[*5])
    else $error("acknowledge data phase too early");
  chk_wait_stretch: assert property (ctlOeCpu && !dataStrobeN && !waitN |=> !dataStrobeN)
    else $error("cycle ended while wait low");
  chk_grant_float: assert property (!busGrantOutN |-> !ctlOeCpu && !adOeCpu)
    else $error("grant while still driving");
  chk_grant_bound: assert property ($fell(busRequestInN) |-> ##[1:80] !busGrantOutN)
    else $error("grant not given");
  chk_grant_held: assert property (!busGrantOutN && !busRequestInN |=> !busGrantOutN)
    else $error("grant dropped while requested");
  chk_grant_back: assert property ($rose(busRequestInN) |-> ##[1:6] busGrantOutN)
    else $error("grant not returned");
endmodule

// ---- verification/cpu_mux_bus_interface_tb.sv ----
// testbench: device end and bus requester joined over the shared bus
`timescale 1ns/1ps
module cpu_mux_bus_interface_tb;
  import cmb_pkg::*;
  logic        mclk, reset, reqValid, reqReady, rspValid, rspReady, irqV;
  logic        xferValid, xferReady, xferRead, xferDone;
  logic [15:0] flag_control_word, rspData, xAddr, xWd, xRd, lvl, lastLvl, latA;
  logic [15:0] mem [0:255];
  logic [15:0] sh [0:255];
  logic [3:0]  irqT, seenSt;
  cmb_req_t    req;
  int          failures, tests_run, irqCnt;
  cmb_bus_if   bus ();
  cmb_cpu_end u_cmb_cpu_end (.mclk(mclk), .reset(reset), .bus(bus.cpu), .reqData(req),
    .reqValid(reqValid), .reqReady(reqReady), .flagControlWord(flag_control_word), .rspData(rspData),
    .rspValid(rspValid), .rspReady(rspReady), .irqTaken(irqT), .irqTakenValid(irqV));
  cmb_dma_end u_cmb_dma_end (.mclk(mclk), .reset(reset), .bus(bus.dma), .xferValid(xferValid),
    .xferReady(xferReady), .xferRead(xferRead), .xferCode(ST_MEM_OPND), .xferAddr(xAddr),
    .xferWdata(xWd), .xferRdata(xRd), .xferDone(xferDone));
  cmb_bus_properties u_cmb_bus_properties (.mclk(mclk), .reset(reset),
    .addrStrobeN(bus.addrStrobeN), .dataStrobeN(bus.dataStrobeN),
    .readNotWrite(bus.readNotWrite), .byteNotWord(bus.byteNotWord),
    .memRequestN(bus.memRequestN), .status(bus.status), .ctlOeCpu(bus.ctlOeCpu),
    .adOeCpu(bus.adOeCpu), .adOutCpu(bus.adOutCpu), .waitN(bus.waitN),
    .busRequestInN(bus.busRequestInN), .busGrantOutN(bus.busGrantOutN));
  ////////////////////////////////////////////////////////////////////////////
  // wire level: enabled driver, memory on reads, else a drifting pattern
  always_comb begin
    if (bus.adOeCpu) lvl = bus.adOutCpu;
    else if (bus.adOeDma) lvl = bus.adOutDma;
    else if (!bus.dataStrobeN && bus.readNotWrite) lvl = mem[latA[8:1]];
    else lvl = ~lastLvl;
  end
  assign bus.adIn = lvl;
  // memory: latch address, store lanes, watch status and acks
  always @(posedge mclk) begin
    lastLvl <= reset ? 16'h0000 : lvl;
    bus.waitN <= ($urandom % 4) != 0;
    irqCnt <= reset ? 0 : irqCnt + int'(irqV === 1'b1);
    if (!bus.addrStrobeN) latA <= lvl;
    // a fresh take clears the status seen, so a strobeless cycle reads as internal
    if (reqValid && reqReady) seenSt <= 4'h0;
    else if (!bus.addrStrobeN && bus.ctlOeCpu) seenSt <= bus.status;
    if (!bus.dataStrobeN && !bus.readNotWrite) begin
      if (!bus.byteNotWord) mem[latA[8:1]] <= lvl;
      else if (latA[0]) mem[latA[8:1]][7:0] <= lvl[7:0];
      else mem[latA[8:1]][15:8] <= lvl[15:8];
    end
  end
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] expSt(input logic [3:0] c);
    return (c[3] && c[1]) ? 4'h0 : c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cpuReq(input logic [3:0] c, input logic rd, input logic bw,
                        input logic [15:0] a, input logic [15:0] d);
    int n;
    @(posedge mclk);
    req <= '{code: c, rdNotWr: rd, byteXfer: bw, seg: 7'h00, addr: a, wdata: d};
    reqValid <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (reqReady !== 1'b1 && n < 300);
    chk(16'(reqReady === 1'b1), 16'h0001);
    reqValid <= 1'b0;
  endtask
  task automatic popChk(input logic [15:0] exp);
    int n;
    n = 0;
    do begin @(posedge mclk); n++; end while (rspValid !== 1'b1 && n < 300);
    chk(16'(rspValid === 1'b1), 16'h0001);
    chk(rspData, exp);
  endtask
  task automatic rdWord(input logic [15:0] a, input logic [15:0] exp);
    cpuReq(ST_MEM_OPND, 1'b1, 1'b0, a, 16'h0000);
    popChk(exp);
  endtask
  task automatic irqChk(input logic [3:0] exp);
    int n;
    n = 0;
    do begin @(posedge mclk); n++; end while (irqV !== 1'b1 && n < 300);
    chk(16'(irqV === 1'b1), 16'h0001);
    chk(16'(irqT), 16'(exp));
  endtask
  task automatic dmaXfer(input logic rd, input logic [15:0] a, input logic [15:0] d);
    int n;
    @(posedge mclk);
    xferValid <= 1'b1;
    xferRead <= rd;
    xAddr <= a;
    xWd <= d;
    n = 0;
    do begin @(posedge mclk); n++; end while (xferReady !== 1'b1 && n < 300);
    chk(16'(xferReady === 1'b1), 16'h0001);
    xferValid <= 1'b0;
    n = 0;
    do begin @(posedge mclk); n++; end while (xferDone !== 1'b1 && n < 300);
    chk(16'(xferDone === 1'b1), 16'h0001);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] a, d;
    int          k;
    {reset, rspReady, flag_control_word, req} = {1'b1, 1'b1, 16'h1800, 45'h0};
    {reqValid, xferValid, xferRead, xAddr, xWd, failures, tests_run} = '0;
    {bus.nmiN, bus.vectoredIrqN, bus.plainIrqN, bus.segmentTrapN} = 4'hf;
    for (int i = 0; i < 256; i++) {mem[i], sh[i]} = 32'h0;
    k = $urandom(49);
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({12'h0, bus.addrStrobeN, bus.dataStrobeN, bus.busGrantOutN, rspValid}, 16'h000e);
    chk(16'(bus.statusCpu), 16'h0000);
    chk(16'(bus.normalNotSysCpu), 16'h0001);
    // random word and byte traffic, first with an odd word address
    for (int i = 0; i < 16; i++) begin
      a = (i == 0) ? 16'h01ff : 16'($urandom % 512);
      d = 16'($urandom);
      cpuReq(ST_MEM_STACK, 1'b0, 1'b0, a, d);
      sh[a[8:1]] = d;
      a = a ^ 16'h0001;
      cpuReq(ST_MEM_OPND, 1'b0, 1'b1, a, {8'h00, ~d[7:0]});
      if (a[0]) sh[a[8:1]][7:0] = ~d[7:0];
      else sh[a[8:1]][15:8] = ~d[7:0];
      rdWord(a, sh[a[8:1]]);
    end
    // every request code except the acknowledge codes 4 to 7, reserved ones included
    for (int c = 0; c < 16; c++) begin
      if (c < 4 || c > 7) begin
        cpuReq(4'(c), 1'b0, 1'b0, 16'h0180, 16'(c));
        repeat (12) @(posedge mclk);
        chk(16'(seenSt), 16'(expSt(4'(c))));
      end
    end
    // bus handed to the requester and back
    cpuReq(ST_MEM_OPND, 1'b0, 1'b0, 16'h0100, 16'h5aa5);
    dmaXfer(1'b1, 16'h0100, 16'h0000);
    chk(xRd, 16'h5aa5);
    dmaXfer(1'b0, 16'h0102, 16'ha55a);
    rdWord(16'h0102, 16'ha55a);
    // two reads parked while the receiver stalls
    rspReady <= 1'b0;
    cpuReq(ST_MEM_OPND, 1'b1, 1'b0, 16'h0100, 16'h0000);
    cpuReq(ST_MEM_OPND, 1'b1, 1'b0, 16'h0102, 16'h0000);
    repeat (30) @(posedge mclk);
    chk(16'(reqReady), 16'h0000);
    rspReady <= 1'b1;
    popChk(16'h5aa5);
    popChk(16'ha55a);
    // interrupt priorities
    bus.vectoredIrqN <= 1'b0;
    bus.plainIrqN <= 1'b0;
    irqChk(ST_VEC_ACK);
    bus.vectoredIrqN <= 1'b1;
    irqChk(ST_PLAIN_ACK);
    bus.plainIrqN <= 1'b1;
    @(posedge mclk);
    bus.nmiN <= 1'b0;
    bus.segmentTrapN <= 1'b0;
    irqChk(ST_SEGMENT_TRAP_N_ACK);
    bus.segmentTrapN <= 1'b1;
    irqChk(ST_NMI_ACK);
    bus.nmiN <= 1'b1;
    // masked vectored request in system mode, then enabled
    @(posedge mclk);
    flag_control_word <= 16'h4000;
    bus.vectoredIrqN <= 1'b0;
    k = irqCnt;
    repeat (40) @(posedge mclk);
    chk(16'(irqCnt - k), 16'h0000);
    chk(16'(bus.normalNotSysCpu), 16'h0000);
    flag_control_word <= 16'h1000;
    irqChk(ST_VEC_ACK);
    bus.vectoredIrqN <= 1'b1;
    tally_and_finish();
  end
endmodule
